// file: pcl_host_model.sv
`timescale 1ns/1ns
module pcl_host_model #(
    parameter int LATCH_CYCLES = 20,
    parameter int OFF_CYCLES   = 20
) (
    input  wire logic sys_clk,
    output logic      ctrlPin
);
    // Pin starts low, so the part sits in shutdown until the first burst
    initial ctrlPin = 1'b0;

    // Pulses of two cycles low, two high; the low part stays far below the off timeout
    task automatic send_edges(input int edges, input int hold);
        for (int i = 0; i < edges; i++)
        begin
            ctrlPin = 1'b0;
            repeat (2) @(negedge sys_clk);
            ctrlPin = 1'b1;
            repeat (2) @(negedge sys_clk);
        end
        repeat (hold) @(negedge sys_clk);
    endtask : send_edges

    // Full burst with a pause well past the latch timeout
    task automatic send_burst(input int edges);
        send_edges(edges, LATCH_CYCLES + 8);
    endtask : send_burst

    // Address burst, pause, data burst, pause
    task automatic write_reg(input int addr, input int data);
        send_burst(addr + 16);
        send_burst(data);
    endtask : write_reg

    // Low for longer than the off timeout; pin is left low afterwards
    task automatic shut_down();
        ctrlPin = 1'b0;
        repeat (OFF_CYCLES + 8) @(negedge sys_clk);
    endtask : shut_down
endmodule : pcl_host_model

// file: pcl_led_ctrl.sv
`timescale 1ns/1ns
module pcl_led_ctrl #(
    parameter int LATCH_CYCLES = pcl_pkg::LATCH_CYCLES,
    parameter int OFF_CYCLES   = pcl_pkg::OFF_CYCLES
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              ctrlPin,
    output logic                   active,
    output logic [3:0]             mainCode,
    output logic [3:0]             subCode,
    output logic [3:0]             scaleCode,
    output logic [3:0]             lowCode,
    output pcl_pkg::pcl_scale_e    scaleSel,
    output logic [3:0]             mainLevel,
    output logic [3:0]             subLevel,
    output logic                   mainLowOn,
    output logic                   subLowOn,
    output logic [1:0]             lowLevel
);
    localparam int MAX_CYC = (LATCH_CYCLES > OFF_CYCLES) ? LATCH_CYCLES : OFF_CYCLES;
    localparam int TW      = $clog2(MAX_CYC) + 1;
    localparam logic [TW-1:0] LATCH_LAST = TW'(LATCH_CYCLES - 1);
    localparam logic [TW-1:0] OFF_LAST   = TW'(OFF_CYCLES - 1);
    localparam logic [TW-1:0] TIMER_ONE  = TW'(1);

    // Pin synchroniser; pinMeta feeds only pinSync
    logic                  pinMeta;
    logic                  pinSync;
    logic                  pinLast;
    logic                  rising;

    pcl_pkg::pcl_state_e   state;
    pcl_pkg::pcl_state_e   next_state;
    logic [4:0]            edgeCount;
    logic [4:0]            next_edgeCount;
    logic [TW-1:0]         highTimer;
    logic [TW-1:0]         next_highTimer;
    logic [TW-1:0]         lowTimer;
    logic [TW-1:0]         next_lowTimer;
    logic [2:0]            addr;
    logic [2:0]            next_addr;
    logic [3:0]            next_mainCode;
    logic [3:0]            next_subCode;
    logic [3:0]            next_scaleCode;
    logic [3:0]            next_lowCode;
    logic                  latchNow;
    logic                  offNow;

    // Output decode group
    logic                  next_active;
    pcl_pkg::pcl_scale_e   next_scaleSel;
    logic [3:0]            next_mainLevel;
    logic [3:0]            next_subLevel;
    logic                  next_mainLowOn;
    logic                  next_subLowOn;
    logic [1:0]            next_lowLevel;
    logic [3:0]            lowIdx;

    // Saturating edge count keeps overlong bursts recognisable
    function automatic logic [4:0] satInc(input logic [4:0] v);
        satInc = (v == pcl_pkg::COUNT_SAT) ? v : 5'(v + pcl_pkg::COUNT_ONE);
    endfunction : satInc

    // Two flops before any logic looks at the pin
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pinMeta <= 1'b0;
            pinSync <= 1'b0;
            pinLast <= 1'b0;
        end
        else
        begin
            pinMeta <= ctrlPin;
            pinSync <= pinMeta;
            pinLast <= pinSync;
        end
    end

    assign rising   = pinSync & ~pinLast;
    assign latchNow = (state == pcl_pkg::ST_BURST) && pinSync && !rising && (highTimer == LATCH_LAST);
    assign offNow   = (state != pcl_pkg::ST_OFF) && !pinSync && (lowTimer == OFF_LAST);

    // Burst counting, latching and shutdown
    always_comb
    begin
        next_state     = state;
        next_edgeCount = edgeCount;
        next_addr      = addr;
        next_mainCode  = mainCode;
        next_subCode   = subCode;
        next_scaleCode = scaleCode;
        next_lowCode   = lowCode;
        // Timers measure one continuous level each
        next_highTimer = pinSync ? TW'(highTimer + TIMER_ONE) : '0;
        next_lowTimer  = pinSync ? '0 : ((lowTimer == OFF_LAST) ? lowTimer : TW'(lowTimer + TIMER_ONE));
        if (offNow)
        begin
            // Long low: shut down and restore defaults
            next_state     = pcl_pkg::ST_OFF;
            next_edgeCount = '0;
            next_addr      = pcl_pkg::ADDR_BOTH;
            next_mainCode  = pcl_pkg::REG_RESET;
            next_subCode   = pcl_pkg::REG_RESET;
            next_scaleCode = pcl_pkg::REG_RESET;
            next_lowCode   = pcl_pkg::REG_RESET;
        end
        else if (rising)
        begin
            // First edge after shutdown also wakes the device
            next_state     = pcl_pkg::ST_BURST;
            next_edgeCount = (state == pcl_pkg::ST_BURST) ? satInc(edgeCount) : pcl_pkg::COUNT_ONE;
            next_highTimer = '0;
        end
        else if (latchNow)
        begin
            next_state     = pcl_pkg::ST_IDLE;
            next_edgeCount = '0;
            if (edgeCount <= pcl_pkg::DATA_MAX)
            begin
                // Data: code 16 wraps to 4'h0 in the 4-bit register
                case (addr)
                    pcl_pkg::ADDR_BOTH:
                    begin
                        next_mainCode = edgeCount[3:0];
                        next_subCode  = edgeCount[3:0];
                    end
                    pcl_pkg::ADDR_MAIN:  next_mainCode  = edgeCount[3:0];
                    pcl_pkg::ADDR_SUB:   next_subCode   = edgeCount[3:0];
                    pcl_pkg::ADDR_SCALE: next_scaleCode = edgeCount[3:0];
                    pcl_pkg::ADDR_LOW:   next_lowCode   = edgeCount[3:0];
                    default:             next_lowCode   = lowCode;
                endcase
            end
            else if (edgeCount <= pcl_pkg::ADDR_MAX)
            begin
                next_addr = 3'(edgeCount - pcl_pkg::ADDR_BIAS);
            end
            // Longer bursts fall through unchanged
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state     <= pcl_pkg::ST_OFF;
            edgeCount <= '0;
            highTimer <= '0;
            lowTimer  <= '0;
            addr      <= pcl_pkg::ADDR_BOTH;
            mainCode  <= pcl_pkg::REG_RESET;
            subCode   <= pcl_pkg::REG_RESET;
            scaleCode <= pcl_pkg::REG_RESET;
            lowCode   <= pcl_pkg::REG_RESET;
        end
        else
        begin
            state     <= next_state;
            edgeCount <= next_edgeCount;
            highTimer <= next_highTimer;
            lowTimer  <= next_lowTimer;
            addr      <= next_addr;
            mainCode  <= next_mainCode;
            subCode   <= next_subCode;
            scaleCode <= next_scaleCode;
            lowCode   <= next_lowCode;
        end
    end

    // Sink control decode; lags the registers by one cycle, harmless for analog
    always_comb
    begin
        lowIdx         = 4'(lowCode - pcl_pkg::LOW_BIAS);
        next_active    = (state != pcl_pkg::ST_OFF);
        next_mainLevel = mainCode;
        next_subLevel  = subCode;
        next_mainLowOn = 1'b0;
        next_subLowOn  = 1'b0;
        next_lowLevel  = lowIdx[1:0];
        case (scaleCode)
            pcl_pkg::SCALE_30:  next_scaleSel = pcl_pkg::SEL_30;
            pcl_pkg::SCALE_15:  next_scaleSel = pcl_pkg::SEL_15;
            pcl_pkg::SCALE_LOW: next_scaleSel = pcl_pkg::SEL_LOW;
            default:            next_scaleSel = pcl_pkg::SEL_20;
        endcase
        if (scaleCode == pcl_pkg::SCALE_LOW)
        begin
            // Channel codes have no say in low-current mode
            next_mainLevel = pcl_pkg::CODE_OFF;
            next_subLevel  = pcl_pkg::CODE_OFF;
            next_mainLowOn = (lowIdx[3:2] == pcl_pkg::LOW_GRP_MAIN) || (lowIdx[3:2] == pcl_pkg::LOW_GRP_BOTH);
            next_subLowOn  = (lowIdx[3:2] == pcl_pkg::LOW_GRP_SUB) || (lowIdx[3:2] == pcl_pkg::LOW_GRP_BOTH);
        end
        if (state == pcl_pkg::ST_OFF)
        begin
            // Shutdown: everything dark
            next_mainLevel = pcl_pkg::CODE_OFF;
            next_subLevel  = pcl_pkg::CODE_OFF;
            next_mainLowOn = 1'b0;
            next_subLowOn  = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            active    <= 1'b0;
            scaleSel  <= pcl_pkg::SEL_20;
            mainLevel <= pcl_pkg::CODE_OFF;
            subLevel  <= pcl_pkg::CODE_OFF;
            mainLowOn <= 1'b0;
            subLowOn  <= 1'b0;
            lowLevel  <= '0;
        end
        else
        begin
            active    <= next_active;
            scaleSel  <= next_scaleSel;
            mainLevel <= next_mainLevel;
            subLevel  <= next_subLevel;
            mainLowOn <= next_mainLowOn;
            subLowOn  <= next_subLowOn;
            lowLevel  <= next_lowLevel;
        end
    end

    // Checks on the decoder
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_edge_starts_burst: assert property (
        rising && !offNow |=> state == pcl_pkg::ST_BURST)
        else $error("Rising edge did not enter burst state");

    a_latch_after_high: assert property (
        state == pcl_pkg::ST_BURST && !pinSync ##1 rising ##1 (pinSync && !rising) [*8]
        |-> state == pcl_pkg::ST_BURST)
        else $error("Burst latched before pin stayed high");

    a_addr_from_count: assert property (
        latchNow && edgeCount > pcl_pkg::DATA_MAX && edgeCount <= pcl_pkg::ADDR_MAX
        |=> addr == 3'($past(edgeCount) - pcl_pkg::ADDR_BIAS))
        else $error("Address not edge count minus sixteen");

    a_both_channels: assert property (
        latchNow && edgeCount <= pcl_pkg::DATA_MAX && addr == pcl_pkg::ADDR_BOTH
        |=> mainCode == $past(edgeCount[3:0]) && subCode == $past(edgeCount[3:0]))
        else $error("Address one did not load both channels");

    a_main_only: assert property (
        latchNow && edgeCount <= pcl_pkg::DATA_MAX && addr == pcl_pkg::ADDR_MAIN
        |=> $stable(subCode) && mainCode == $past(edgeCount[3:0]))
        else $error("Main write disturbed sub channel");

    a_addr_held: assert property (
        latchNow && edgeCount <= pcl_pkg::DATA_MAX |=> $stable(addr))
        else $error("Data burst changed the address");

    a_shutdown_reset: assert property (
        offNow |=> state == pcl_pkg::ST_OFF && mainCode == pcl_pkg::REG_RESET
        && subCode == pcl_pkg::REG_RESET && scaleCode == pcl_pkg::REG_RESET
        && lowCode == pcl_pkg::REG_RESET ##1 !active)
        else $error("Shutdown did not restore register defaults");

    a_off_addr_one: assert property (
        state == pcl_pkg::ST_OFF |-> addr == pcl_pkg::ADDR_BOTH)
        else $error("Address not one while disabled");

    a_long_ignored: assert property (
        latchNow && edgeCount > pcl_pkg::ADDR_MAX
        |=> $stable(addr) && $stable(mainCode) && $stable(subCode) && $stable(scaleCode) && $stable(lowCode))
        else $error("Overlong burst changed a register");

    a_low_mode_dark: assert property (
        scaleCode == pcl_pkg::SCALE_LOW |=> scaleSel == pcl_pkg::SEL_LOW
        && mainLevel == pcl_pkg::CODE_OFF && subLevel == pcl_pkg::CODE_OFF)
        else $error("Channel codes leaked in low-current mode");

    a_low_groups: assert property (
        scaleCode == pcl_pkg::SCALE_LOW && state != pcl_pkg::ST_OFF
        && lowCode >= 4'h5 && lowCode <= 4'h8 |=> subLowOn && !mainLowOn)
        else $error("Low codes five to eight must drive sub only");

    a_scale_thirty: assert property (
        scaleCode == pcl_pkg::SCALE_30 |=> scaleSel == pcl_pkg::SEL_30)
        else $error("Scale value two did not select the thirty scale");

    a_scale_default: assert property (
        scaleCode == pcl_pkg::REG_RESET |=> scaleSel == pcl_pkg::SEL_20)
        else $error("Reset scale value did not select the twenty scale");

    a_code_row: assert property (
        scaleCode != pcl_pkg::SCALE_LOW && state != pcl_pkg::ST_OFF
        |=> mainLevel == $past(mainCode) && subLevel == $past(subCode))
        else $error("Sink code did not follow the channel register");

    a_off_dark: assert property (
        state == pcl_pkg::ST_OFF
        |=> mainLevel == pcl_pkg::CODE_OFF && subLevel == pcl_pkg::CODE_OFF && !mainLowOn && !subLowOn)
        else $error("Sinks not dark in shutdown");
endmodule : pcl_led_ctrl

// file: pcl_led_ctrl_tb.sv
`timescale 1ns/1ns
module pcl_led_ctrl_tb;
    // Short timeouts keep the run small
    localparam int LAT = 20;
    localparam int OFF = 20;
    logic                sys_clk;
    logic                rst;
    wire logic           ctrlPin;
    logic                active;
    logic [3:0]          mainCode;
    logic [3:0]          subCode;
    logic [3:0]          scaleCode;
    logic [3:0]          lowCode;
    pcl_pkg::pcl_scale_e scaleSel;
    logic [3:0]          mainLevel;
    logic [3:0]          subLevel;
    logic                mainLowOn;
    logic                subLowOn;
    logic [1:0]          lowLevel;
    int                  n_mismatch = 0;
    int                  n_checks = 0;
    int                  cycles = 0;

    pcl_led_ctrl #(.LATCH_CYCLES(LAT), .OFF_CYCLES(OFF)) uut (
        .sys_clk(sys_clk), .rst(rst), .ctrlPin(ctrlPin), .active(active),
        .mainCode(mainCode), .subCode(subCode), .scaleCode(scaleCode), .lowCode(lowCode),
        .scaleSel(scaleSel), .mainLevel(mainLevel), .subLevel(subLevel),
        .mainLowOn(mainLowOn), .subLowOn(subLowOn), .lowLevel(lowLevel)
    );

    // Model defaults already equal the short timeouts above
    pcl_host_model host (
        .sys_clk(sys_clk), .ctrlPin(ctrlPin)
    );

    // 125 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Hang guard, far above the roughly two thousand cycles the tests need
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Channel registers and the sink codes that follow them on a normal scale
    task automatic check_chan(input logic [3:0] m, input logic [3:0] s);
        check("mainCode", mainCode, m);
        check("subCode", subCode, s);
        check("mainLevel", mainLevel, m);
        check("subLevel", subLevel, s);
    endtask : check_chan

    // Inactive, all four registers back at 1 and the 20 mA scale
    task automatic check_off();
        check("active", {3'h0, active}, 4'h0);
        check("mainCode", mainCode, 4'h1);
        check("subCode", subCode, 4'h1);
        check("scaleCode", scaleCode, 4'h1);
        check("lowCode", lowCode, 4'h1);
        check("scaleSel", {2'h0, scaleSel}, {2'h0, pcl_pkg::SEL_20});
    endtask : check_off

    // No address sent: first data burst lands on both channels
    task automatic t_default_addr();
        host.send_burst(5);
        check("active", {3'h0, active}, 4'h1);
        check_chan(4'h5, 4'h5);
    endtask : t_default_addr

    // Main only, repeated data without readdressing, then sub to code 16
    task automatic t_split();
        host.write_reg(2, 7);
        check_chan(4'h7, 4'h5);
        host.send_burst(3);
        check_chan(4'h3, 4'h5);
        host.write_reg(3, 16);
        check_chan(4'h3, 4'h0);
    endtask : t_split

    // A pause shorter than the latch timeout joins two groups into one burst
    task automatic t_short_pause();
        host.send_burst(18);
        host.send_edges(2, LAT - 8);
        check("mainCode", mainCode, 4'h3);
        host.send_burst(2);
        check_chan(4'h4, 4'h0);
    endtask : t_short_pause

    // Every scale value; channel codes stay put, low mode zeroes the sinks
    task automatic t_scale();
        logic [3:0]          vals [4] = '{4'h2, 4'h3, 4'h1, 4'h4};
        pcl_pkg::pcl_scale_e sels [4] = '{pcl_pkg::SEL_30, pcl_pkg::SEL_15, pcl_pkg::SEL_20, pcl_pkg::SEL_LOW};
        for (int i = 0; i < 4; i++)
        begin
            host.write_reg(4, int'(vals[i]));
            check("scaleCode", scaleCode, vals[i]);
            check("scaleSel", {2'h0, scaleSel}, {2'h0, sels[i]});
            check("mainCode", mainCode, 4'h4);
            check("mainLevel", mainLevel, (i == 3) ? 4'h0 : 4'h4);
        end
    endtask : t_scale

    // One code from each low-current group plus code 16
    task automatic t_low();
        int codes [5] = '{1, 5, 9, 13, 16};
        int c;
        host.send_burst(21);
        for (int i = 0; i < 5; i++)
        begin
            c = codes[i];
            host.send_burst(c);
            check("lowCode", lowCode, c[3:0]);
            check("mainLowOn", {3'h0, mainLowOn}, ((c - 1) / 4 >= 2) ? 4'h1 : 4'h0);
            check("subLowOn", {3'h0, subLowOn}, ((c - 1) / 4 % 2 == 1) ? 4'h1 : 4'h0);
            check("lowLevel", {2'h0, lowLevel}, 4'((c - 1) % 4));
            check("subLevel", subLevel, 4'h0);
        end
    endtask : t_low

    // Over-long burst must leave every register alone
    task automatic t_ignore();
        host.send_burst(22);
        check("lowCode", lowCode, 4'h0);
        check("scaleCode", scaleCode, 4'h4);
        check("mainCode", mainCode, 4'h4);
        check("subCode", subCode, 4'h0);
        host.send_burst(9);
        check("lowCode", lowCode, 4'h9);
    endtask : t_ignore

    // Shutdown sets every register back to 1; next burst goes to address 1 again
    task automatic t_shutdown();
        host.shut_down();
        check_off();
        host.send_burst(6);
        check_chan(4'h6, 4'h6);
    endtask : t_shutdown

    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // Reset for 10 cycles, then the scenarios in order
    initial
    begin
        rst = 1'b1;
        repeat (10) @(negedge sys_clk);
        check_off();
        rst = 1'b0;
        @(negedge sys_clk);
        t_default_addr();
        t_split();
        t_short_pause();
        t_scale();
        t_low();
        t_ignore();
        t_shutdown();
        tally_and_finish();
    end
endmodule : pcl_led_ctrl_tb

// file: pcl_pkg.sv
// Operation
// - Address and data come only from counting rising edges within one burst.
// - A burst is latched only after the pin stays high for the latch timeout.
// - Latch is guaranteed when the pin stays high over 500 us after the last edge.
// - A burst of 17 or more edges is address, number equal to edges minus 16; code takes 17 to 21 only, longer bursts are ignored.
// - A burst of 1 to 16 edges is data, written into the addressed register.
// - Once an address is latched, further data bursts go to the same register.
// - Pin held low longer than the off timeout puts the device into shutdown.
// - Off timeout is guaranteed when the pin stays low over 500 us.
// - Every shutdown entry resets all data registers to 1.
// - After disable, address 1 is current from the first edge until changed.
// - Addresses: 1 both channels, 2 main, 3 sub, 4 full scale, 5 low current.
// - Data to address 1 loads the same code into main and sub registers.
// - Addresses 2 and 3 update only main or only sub, other one unchanged.
// - Full scale value 1 is 20 mA, 2 is 30 mA, 3 is 15 mA, 4 low-current mode.
// - With full scale 4, sinks follow the low-current register, channel codes ignored.
// - The 20 mA scale is used until the full-scale register is rewritten.
// - Channel codes 1 to 15 step down about 1 dB each; code 16 is zero current.
// - Changing scale keeps channel codes, outputs move to the same row.
// - Low codes 1-4 off, 5-8 sub, 9-12 main, 13-16 both, four current levels.
package pcl_pkg;
    // Timing
    localparam int CLK_PERIOD_NS    = 8;
    localparam int LATCH_TIMEOUT_NS = 500000;
    localparam int OFF_TIMEOUT_NS   = 500000;
    // Longest times, so round down; pin sync and edge stage eat the first cycles
    localparam int SYNC_LAG_CYCLES  = 3;
    localparam int LATCH_CYCLES     = LATCH_TIMEOUT_NS / CLK_PERIOD_NS - SYNC_LAG_CYCLES;
    localparam int OFF_CYCLES       = OFF_TIMEOUT_NS / CLK_PERIOD_NS - SYNC_LAG_CYCLES;

    // Edge counter
    localparam int          COUNT_W   = 5;
    localparam logic [4:0]  COUNT_ONE = 5'h01;
    localparam logic [4:0]  COUNT_SAT = 5'h1f;
    localparam logic [4:0]  DATA_MAX  = 5'h10;
    localparam logic [4:0]  ADDR_MAX  = 5'h15;
    localparam logic [4:0]  ADDR_BIAS = 5'h10;

    // Register addresses
    localparam logic [2:0]  ADDR_BOTH  = 3'h1;
    localparam logic [2:0]  ADDR_MAIN  = 3'h2;
    localparam logic [2:0]  ADDR_SUB   = 3'h3;
    localparam logic [2:0]  ADDR_SCALE = 3'h4;
    localparam logic [2:0]  ADDR_LOW   = 3'h5;

    // Register values; code 16 is held as 4'h0
    localparam logic [3:0]  REG_RESET  = 4'h1;
    localparam logic [3:0]  CODE_OFF   = 4'h0;
    localparam logic [3:0]  SCALE_20   = 4'h1;
    localparam logic [3:0]  SCALE_30   = 4'h2;
    localparam logic [3:0]  SCALE_15   = 4'h3;
    localparam logic [3:0]  SCALE_LOW  = 4'h4;
    localparam logic [3:0]  LOW_BIAS   = 4'h1;

    // Low-current groups (code minus one, upper two bits)
    localparam logic [1:0]  LOW_GRP_SUB  = 2'h1;
    localparam logic [1:0]  LOW_GRP_MAIN = 2'h2;
    localparam logic [1:0]  LOW_GRP_BOTH = 2'h3;

    typedef enum logic [1:0] {
        SEL_20  = 2'b00,
        SEL_30  = 2'b01,
        SEL_15  = 2'b10,
        SEL_LOW = 2'b11
    } pcl_scale_e;

    typedef enum logic [1:0] {
        ST_OFF   = 2'b00,
        ST_IDLE  = 2'b01,
        ST_BURST = 2'b10
    } pcl_state_e;
endpackage : pcl_pkg
